// ==== src/csl_pkg.sv ====
// Package with constants and types shared by the strap latch and decode block.
package csl_pkg;

  // ----------------------------------------------------------------------
  // Sensed resistor option codes on a strap pin
  // ----------------------------------------------------------------------
  localparam int unsigned STRAP_W = 3;
  localparam logic [2:0] RES_PD_200K = 3'h0;
  localparam logic [2:0] RES_PU_200K = 3'h1;
  localparam logic [2:0] RES_PD_10K = 3'h2;
  localparam logic [2:0] RES_PU_10K = 3'h3;
  localparam logic [2:0] RES_PD_10R = 3'h4;

  // ----------------------------------------------------------------------
  // Decoded port counts and mode straps
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W = 3;
  localparam logic [2:0] CNT_NONE = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_THREE = 3'h3;
  localparam logic [2:0] CNT_FOUR = 3'h4;
  localparam int unsigned MODE_STRAPS = 3;
  localparam int unsigned MODE_W = MODE_STRAPS * STRAP_W;

  // ----------------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------------
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] SETTLE_RST = 2'h0;

  typedef enum logic [1:0] {
    CSL_ST_SETTLE = 2'b00,
    CSL_ST_CAPTURE = 2'b01,
    CSL_ST_HOLD = 2'b11
  } csl_state_type;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FIXED_CFG = 8'h04;
  localparam logic [7:0] ADDR_CHARGE_CFG = 8'h08;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h0C;
  localparam logic [7:0] ADDR_EFFECTIVE = 8'h10;
  localparam int unsigned ST_FIXED_LSB = 0;
  localparam int unsigned ST_CHARGE_LSB = 3;
  localparam int unsigned ST_MODE_LSB = 6;
  localparam int unsigned ST_FIXED_RSVD = 16;
  localparam int unsigned ST_CHARGE_RSVD = 17;
  localparam int unsigned ST_LATCHED = 24;
  localparam int unsigned CFG_VAL_LSB = 0;
  localparam int unsigned CFG_OVR_BIT = 16;
  localparam int unsigned EFF_FIXED_LSB = 0;
  localparam int unsigned EFF_CHARGE_LSB = 8;
  localparam int unsigned EFF_MODE_LSB = 16;
  localparam logic [2:0] CFG_CNT_RST = 3'h0;
  localparam logic [8:0] CFG_MODE_RST = 9'h000;
  localparam logic CFG_OVR_RST = 1'b0;

endpackage

// ==== src/csl_strap_latch.sv ====
// Strap latch and decode block with an APB register slave.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module csl_strap_latch #(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] fixed_port_strap,
  input wire logic [2:0] charge_port_strap,
  input wire logic [8:0] mode_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic straps_latched,
  output logic [NUM_PORTS-1:0] nonrem_port_en,
  output logic [NUM_PORTS-1:0] dcp_port_en,
  output logic [NUM_PORTS-1:0] cdp_port_en,
  output logic [8:0] device_mode
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The decode reaches four ports, so fewer ports cannot hold every setting.
  if (NUM_PORTS < 4 || NUM_PORTS > 7) begin : g_bad_ports
    $error("NUM_PORTS must be between 4 and 7.");
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Maps a sensed resistor option to a port count; other codes are reserved.
  function automatic logic [2:0] res_to_cnt(input logic [2:0] code);
    logic [2:0] cnt;
    cnt = csl_pkg::CNT_NONE;
    case (code)
      csl_pkg::RES_PD_200K: cnt = csl_pkg::CNT_NONE;
      csl_pkg::RES_PU_200K: cnt = csl_pkg::CNT_ONE;
      csl_pkg::RES_PD_10K: cnt = csl_pkg::CNT_TWO;
      csl_pkg::RES_PU_10K: cnt = csl_pkg::CNT_THREE;
      csl_pkg::RES_PD_10R: cnt = csl_pkg::CNT_FOUR;
      default: cnt = csl_pkg::CNT_NONE;
    endcase
    return cnt;
  endfunction

  // Flags a sensed resistor code that matches none of the five options.
  function automatic logic res_reserved(input logic [2:0] code);
    return code > csl_pkg::RES_PD_10R;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [14:0] sync1_q;
  logic [14:0] sync2_q;
  logic [14:0] sync1_d;
  logic [14:0] sync2_d;

  // The strap pins are asynchronous, so two flops precede any logic.
  always_comb begin
    sync1_d = {mode_strap, charge_port_strap, fixed_port_strap};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 15'h0000;
      sync2_q <= 15'h0000;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ----------------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------------
  csl_pkg::csl_state_type state_q;
  csl_pkg::csl_state_type state_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic [2:0] fixed_code_q;
  logic [2:0] fixed_code_d;
  logic [2:0] charge_code_q;
  logic [2:0] charge_code_d;
  logic [8:0] mode_code_q;
  logic [8:0] mode_code_d;

  // After reset release the sync chain is filled, then the levels are caught once.
  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    fixed_code_d = fixed_code_q;
    charge_code_d = charge_code_q;
    mode_code_d = mode_code_q;
    case (state_q)
      csl_pkg::CSL_ST_SETTLE: begin
        settle_d = settle_q + 2'h1;
        if (settle_q == csl_pkg::SETTLE_CYCLES) begin
          state_d = csl_pkg::CSL_ST_CAPTURE;
        end
      end
      csl_pkg::CSL_ST_CAPTURE: begin
        fixed_code_d = sync2_q[2:0];
        charge_code_d = sync2_q[5:3];
        mode_code_d = sync2_q[14:6];
        state_d = csl_pkg::CSL_ST_HOLD;
      end
      csl_pkg::CSL_ST_HOLD: state_d = csl_pkg::CSL_ST_HOLD;
      default: state_d = csl_pkg::CSL_ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= csl_pkg::CSL_ST_SETTLE;
      settle_q <= csl_pkg::SETTLE_RST;
      fixed_code_q <= csl_pkg::RES_PD_200K;
      charge_code_q <= csl_pkg::RES_PD_200K;
      mode_code_q <= csl_pkg::CFG_MODE_RST;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      fixed_code_q <= fixed_code_d;
      charge_code_q <= charge_code_d;
      mode_code_q <= mode_code_d;
    end
  end

  // ----------------------------------------------------------------------
  // Software configuration registers and APB slave
  // ----------------------------------------------------------------------
  logic [2:0] fixed_ovr_cnt_q;
  logic [2:0] fixed_ovr_cnt_d;
  logic fixed_ovr_en_q;
  logic fixed_ovr_en_d;
  logic [2:0] charge_ovr_cnt_q;
  logic [2:0] charge_ovr_cnt_d;
  logic charge_ovr_en_q;
  logic charge_ovr_en_d;
  logic [8:0] mode_ovr_q;
  logic [8:0] mode_ovr_d;
  logic mode_ovr_en_q;
  logic mode_ovr_en_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic setup_hit;
  logic wr_commit;
  logic addr_ok;
  logic [31:0] rd_word;

  // Effective settings feed both the outputs and the read-back word.
  logic [2:0] fixed_cnt_eff;
  logic [2:0] charge_cnt_eff;
  logic [8:0] mode_eff;
  logic fixed_rsvd;
  logic charge_rsvd;
  logic latched;

  always_comb begin
    latched = (state_q == csl_pkg::CSL_ST_HOLD);
    fixed_rsvd = res_reserved(fixed_code_q);
    charge_rsvd = res_reserved(charge_code_q);
    fixed_cnt_eff = fixed_ovr_en_q ? fixed_ovr_cnt_q : res_to_cnt(fixed_code_q);
    charge_cnt_eff = charge_ovr_en_q ? charge_ovr_cnt_q : res_to_cnt(charge_code_q);
    mode_eff = mode_ovr_en_q ? mode_ovr_q : mode_code_q;
  end

  // Address decode and read-back multiplexer; unmapped words read zero.
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      csl_pkg::ADDR_STATUS: begin
        rd_word[csl_pkg::ST_FIXED_LSB +: 3] = fixed_code_q;
        rd_word[csl_pkg::ST_CHARGE_LSB +: 3] = charge_code_q;
        rd_word[csl_pkg::ST_MODE_LSB +: 9] = mode_code_q;
        rd_word[csl_pkg::ST_FIXED_RSVD] = fixed_rsvd;
        rd_word[csl_pkg::ST_CHARGE_RSVD] = charge_rsvd;
        rd_word[csl_pkg::ST_LATCHED] = latched;
      end
      csl_pkg::ADDR_FIXED_CFG: begin
        rd_word[csl_pkg::CFG_VAL_LSB +: 3] = fixed_ovr_cnt_q;
        rd_word[csl_pkg::CFG_OVR_BIT] = fixed_ovr_en_q;
      end
      csl_pkg::ADDR_CHARGE_CFG: begin
        rd_word[csl_pkg::CFG_VAL_LSB +: 3] = charge_ovr_cnt_q;
        rd_word[csl_pkg::CFG_OVR_BIT] = charge_ovr_en_q;
      end
      csl_pkg::ADDR_MODE_CFG: begin
        rd_word[csl_pkg::CFG_VAL_LSB +: 9] = mode_ovr_q;
        rd_word[csl_pkg::CFG_OVR_BIT] = mode_ovr_en_q;
      end
      csl_pkg::ADDR_EFFECTIVE: begin
        rd_word[csl_pkg::EFF_FIXED_LSB +: 3] = fixed_cnt_eff;
        rd_word[csl_pkg::EFF_CHARGE_LSB +: 3] = charge_cnt_eff;
        rd_word[csl_pkg::EFF_MODE_LSB +: 9] = mode_eff;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // The answer is prepared at the setup edge, so every access has no wait state.
  always_comb begin
    setup_hit = psel && !penable;
    wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;
    pready_d = setup_hit;
    pslverr_d = setup_hit ? !addr_ok : 1'b0;
    prdata_d = (setup_hit && !pwrite) ? rd_word : 32'h0000_0000;
    fixed_ovr_cnt_d = fixed_ovr_cnt_q;
    fixed_ovr_en_d = fixed_ovr_en_q;
    charge_ovr_cnt_d = charge_ovr_cnt_q;
    charge_ovr_en_d = charge_ovr_en_q;
    mode_ovr_d = mode_ovr_q;
    mode_ovr_en_d = mode_ovr_en_q;
    if (wr_commit && paddr == csl_pkg::ADDR_FIXED_CFG) begin
      if (pstrb[0]) fixed_ovr_cnt_d = pwdata[csl_pkg::CFG_VAL_LSB +: 3];
      if (pstrb[2]) fixed_ovr_en_d = pwdata[csl_pkg::CFG_OVR_BIT];
    end
    if (wr_commit && paddr == csl_pkg::ADDR_CHARGE_CFG) begin
      if (pstrb[0]) charge_ovr_cnt_d = pwdata[csl_pkg::CFG_VAL_LSB +: 3];
      if (pstrb[2]) charge_ovr_en_d = pwdata[csl_pkg::CFG_OVR_BIT];
    end
    if (wr_commit && paddr == csl_pkg::ADDR_MODE_CFG) begin
      if (pstrb[0]) mode_ovr_d[7:0] = pwdata[7:0];
      if (pstrb[1]) mode_ovr_d[8] = pwdata[8];
      if (pstrb[2]) mode_ovr_en_d = pwdata[csl_pkg::CFG_OVR_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      fixed_ovr_cnt_q <= csl_pkg::CFG_CNT_RST;
      fixed_ovr_en_q <= csl_pkg::CFG_OVR_RST;
      charge_ovr_cnt_q <= csl_pkg::CFG_CNT_RST;
      charge_ovr_en_q <= csl_pkg::CFG_OVR_RST;
      mode_ovr_q <= csl_pkg::CFG_MODE_RST;
      mode_ovr_en_q <= csl_pkg::CFG_OVR_RST;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      fixed_ovr_cnt_q <= fixed_ovr_cnt_d;
      fixed_ovr_en_q <= fixed_ovr_en_d;
      charge_ovr_cnt_q <= charge_ovr_cnt_d;
      charge_ovr_en_q <= charge_ovr_en_d;
      mode_ovr_q <= mode_ovr_d;
      mode_ovr_en_q <= mode_ovr_en_d;
    end
  end

  // ----------------------------------------------------------------------
  // Per-port enables
  // ----------------------------------------------------------------------
  logic [NUM_PORTS-1:0] nonrem_d;
  logic [NUM_PORTS-1:0] nonrem_q;
  logic [NUM_PORTS-1:0] charge_d;
  logic [NUM_PORTS-1:0] charge_q;
  logic [8:0] mode_out_q;
  logic latched_q;

  // Port n is covered when the decoded count exceeds its index.
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    assign nonrem_d[i] = latched && (fixed_cnt_eff > 3'(i));
    assign charge_d[i] = latched && (charge_cnt_eff > 3'(i));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nonrem_q <= '0;
      charge_q <= '0;
      mode_out_q <= 9'h000;
      latched_q <= 1'b0;
    end else begin
      nonrem_q <= nonrem_d;
      charge_q <= charge_d;
      mode_out_q <= latched ? mode_eff : 9'h000;
      latched_q <= latched;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // DCP and CDP together
  assign dcp_port_en = charge_q;
  assign cdp_port_en = charge_q;
  assign nonrem_port_en = nonrem_q;
  assign device_mode = mode_out_q;
  assign straps_latched = latched_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

// ==== bench/csl_strap_board.sv ====
// Board model of the strap resistors on the configuration pins.
`timescale 1ns/10ps
module csl_strap_board (
  input wire logic [2:0] fixed_opt,
  input wire logic [2:0] charge_opt,
  input wire logic [8:0] mode_opt,
  output logic [2:0] fixed_port_strap,
  output logic [2:0] charge_port_strap,
  output logic [8:0] mode_strap
);
  // Fitted resistors are static, so each sensed code follows the part placed.
  assign fixed_port_strap = fixed_opt;
  assign charge_port_strap = charge_opt;
  assign mode_strap = mode_opt;
endmodule

// ==== bench/csl_strap_latch_properties.sv ====
// Checker with the concurrent properties of the strap latch block.
`timescale 1ns/10ps
module csl_strap_latch_properties #(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] fixed_port_strap,
  input wire logic [2:0] charge_port_strap,
  input wire logic [8:0] mode_strap,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic straps_latched,
  input wire logic [NUM_PORTS-1:0] nonrem_port_en,
  input wire logic [NUM_PORTS-1:0] dcp_port_en,
  input wire logic [NUM_PORTS-1:0] cdp_port_en,
  input wire logic [8:0] device_mode
);
  logic wr_acc;
  logic mapped;
  // Completed write and mapped address decode.
  assign wr_acc = psel && penable && pwrite && pready;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h10);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_latch_on_release: assert property ($rose(arst_n) |-> ##[4:6] $rose(straps_latched))
    else $error("straps not latched in time");
  a_latch_holds: assert property (straps_latched |=> straps_latched)
    else $error("latch flag dropped");
  a_gated_before: assert property (!straps_latched |-> !(|nonrem_port_en) && !(|dcp_port_en) && device_mode == 9'h000)
    else $error("outputs active before capture");
  a_charge_pair: assert property (dcp_port_en == cdp_port_en)
    else $error("dcp and cdp differ");
  a_fixed_contig: assert property (((nonrem_port_en + 1'b1) & nonrem_port_en) == '0)
    else $error("non-removable ports not contiguous");
  a_charge_contig: assert property (((dcp_port_en + 1'b1) & dcp_port_en) == '0)
    else $error("charge ports not contiguous");
  a_settings_stable: assert property ($past(straps_latched) && !$past(wr_acc) && !$past(wr_acc, 2)
    |-> $stable(nonrem_port_en) && $stable(dcp_port_en) && $stable(device_mode))
    else $error("settings changed without a write");
  a_one_cycle_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_error_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero while idle");
  c_override: cover property (wr_acc && paddr == 8'h04);
  c_unmapped: cover property (pready && pslverr);
  c_all_fixed: cover property ($rose(straps_latched) && (&nonrem_port_en));
endmodule
bind csl_strap_latch csl_strap_latch_properties #(.NUM_PORTS(NUM_PORTS)) csl_props_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .fixed_port_strap(fixed_port_strap),
  .charge_port_strap(charge_port_strap), .mode_strap(mode_strap), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .straps_latched(straps_latched), .nonrem_port_en(nonrem_port_en),
  .dcp_port_en(dcp_port_en), .cdp_port_en(cdp_port_en), .device_mode(device_mode));

// ==== bench/csl_strap_latch_tb.sv ====
// Self-checking testbench of the strap latch block.
`timescale 1ns/10ps
module csl_strap_latch_tb;
  typedef struct {
    logic [2:0] f;
    logic [2:0] c;
    logic [8:0] m;
    logic [3:0] en_f;
    logic [3:0] en_c;
  } csl_row_type;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, straps_latched, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] fixed_opt, charge_opt, fs, cs;
  logic [8:0] mode_opt, ms, device_mode;
  logic [3:0] nonrem_port_en, dcp_port_en, cdp_port_en, pstrb;
  int num_errors, checks_done;
  csl_row_type rows [6];

  csl_strap_board csl_strap_board_inst (.fixed_opt(fixed_opt), .charge_opt(charge_opt),
    .mode_opt(mode_opt), .fixed_port_strap(fs), .charge_port_strap(cs), .mode_strap(ms));
  csl_strap_latch csl_strap_latch_inst (.clk_sys(clk_sys), .arst_n(arst_n), .fixed_port_strap(fs),
    .charge_port_strap(cs), .mode_strap(ms), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .straps_latched(straps_latched), .nonrem_port_en(nonrem_port_en), .dcp_port_en(dcp_port_en),
    .cdp_port_en(cdp_port_en), .device_mode(device_mode));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // APB transfer; the access phase is held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    int k;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(straps_latched, 1'b0);
    arst_n <= 1'b1;
    for (k = 0; k < 20 && straps_latched !== 1'b1; k++) @(negedge clk_sys);
    if (k == 20) begin
      num_errors++;
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {fixed_opt, charge_opt, mode_opt} = '0;
    pstrb = 4'hF;
    rows[0] = '{3'h5, 3'h7, 9'h000, 4'h0, 4'h0};
    rows[1] = '{csl_pkg::RES_PD_200K, csl_pkg::RES_PD_10R, 9'h0D1, 4'h0, 4'hF};
    rows[2] = '{csl_pkg::RES_PD_10K, csl_pkg::RES_PD_10K, 9'h11A, 4'h3, 4'h3};
    rows[3] = '{csl_pkg::RES_PU_10K, csl_pkg::RES_PU_200K, 9'h063, 4'h7, 4'h1};
    rows[4] = '{csl_pkg::RES_PD_10R, csl_pkg::RES_PD_200K, 9'h124, 4'hF, 4'h0};
    rows[5] = '{csl_pkg::RES_PU_200K, csl_pkg::RES_PU_10K, 9'h08A, 4'h1, 4'h7};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      fixed_opt <= rows[i].f;
      charge_opt <= rows[i].c;
      mode_opt <= rows[i].m;
      do_reset();
      check(nonrem_port_en, rows[i].en_f);
      check(dcp_port_en, rows[i].en_c);
      check(cdp_port_en, rows[i].en_c);
      check(device_mode, rows[i].m);
      apb(1'b0, 8'h00, 32'h0);
      check(rd, {7'h00, 1'b1, 6'h00, rows[i].c > 3'h4, rows[i].f > 3'h4, 1'b0, rows[i].m,
        rows[i].c, rows[i].f});
    end
    // Strap changes after capture are ignored.
    fixed_opt <= csl_pkg::RES_PD_10R;
    repeat (8) @(posedge clk_sys);
    check(nonrem_port_en, 4'h1);
    // Software overrides replace the strap defaults.
    apb(1'b1, 8'h04, 32'h00010002);
    apb(1'b1, 8'h08, 32'h00010004);
    apb(1'b1, 8'h0C, 32'h000101FF);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00010002);
    check(nonrem_port_en, 4'h3);
    check(cdp_port_en, 4'hF);
    check(device_mode, 9'h1FF);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h01FF0402);
    apb(1'b1, 8'h04, 32'h00000000);
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    check(er, 1'b0);
    check(nonrem_port_en, 4'h1);
    // A write with only the low byte lane enabled changes only the low mode bits.
    pstrb <= 4'h1;
    apb(1'b1, 8'h0C, 32'h00000055);
    pstrb <= 4'hF;
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h00010155);
    check(device_mode, 9'h155);
    // Unmapped addresses are refused.
    apb(1'b0, 8'h14, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h22, 32'h0);
    check(er, 1'b1);
    // Reset in mid-run drops overrides and latches the new straps.
    do_reset();
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h00000000);
    check(nonrem_port_en, 4'hF);
    check(dcp_port_en, 4'h7);
    check(device_mode, 9'h08A);
    complete_run();
  end
endmodule
